/* rtl/mds_sync_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Multiplier mode: one input is reference and sync
// - Direct clock: sync from separate sync input
// - Locked flag bit 6 on constant phase
// - Lost flag bit 7; host checks low
// - Frame strobe realigns FIFO pointers
// - Lost flag latches until software clears
// - Lock after (11+avg)*64 to *128 cycles
// - Multiplier allows only data-rate sync
// - FIFO-rate clock is data rate over eight
module mds_sync_ctrl
    import mds_pkg::*;
#(
    parameter int PHASE_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic reference_sync_input,
    input wire logic separate_sync_input,
    input wire logic source_data_clock,
    input wire logic frame_strobe,
    output logic fifo_realign,
    output logic [2:0] write_pointer,
    output logic irq
);
    logic [7:0] ctl_q;
    logic [7:0] mask_q;
    logic [7:0] cfg_q;
    logic locked_q;
    logic lost_q;
    logic sync_lvl;
    logic sync_rise_raw;
    logic sync_fall_raw;
    logic sync_prev_q;
    logic sync_ev;
    logic dclk_rise;
    logic frame_lvl;
    logic sync_src;
    logic use_mult;
    logic fifo_rate;
    logic enable;
    mds_state_type state_q;
    logic [PHASE_W-1:0] phase_q;
    logic [PHASE_W-1:0] ref_phase_q;
    logic [15:0] avg_cnt_q;
    logic [15:0] lock_cnt_q;
    logic [2:0] fifo_div_q;
    logic [1:0] frame_cnt_q;
    logic frame_done_q;
    logic [7:0] rdata_d;

    function automatic logic [15:0] avg_count(input logic [2:0] code);
        avg_count = 16'h0001 << code;
    endfunction

    function automatic logic [15:0] lock_cycles(input logic [2:0] code);
        lock_cycles = 16'((MDS_LOCK_BASE + int'(avg_count(code))) * MDS_LOCK_UNIT);
    endfunction

    assign use_mult = cfg_q[MDS_CFG_MULT_BIT];
    assign enable = ctl_q[MDS_CTL_ENABLE_BIT];
    // Bit clear asks for FIFO-rate; multiplier clocking forbids it
    assign fifo_rate = enable & ~ctl_q[MDS_CTL_DATA_RATE_BIT] & ~use_mult;
    // Sync source follows clocking scheme
    assign sync_src = use_mult ? reference_sync_input : separate_sync_input;

    mds_edge_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(sync_src),
        .level_out(sync_lvl),
        .rise_out(sync_rise_raw)
    );

    mds_edge_sync u_dclk (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(source_data_clock),
        .level_out(),
        .rise_out(dclk_rise)
    );

    mds_edge_sync u_frame (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(frame_strobe),
        .level_out(frame_lvl),
        .rise_out()
    );

    // Edge select trades setup against hold margin on the sync sample
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= sync_lvl;
        end
    end
    assign sync_fall_raw = ~sync_lvl & sync_prev_q;
    assign sync_ev = ctl_q[MDS_CTL_EDGE_BIT] ? sync_rise_raw : sync_fall_raw;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= MDS_SYNC_CONTROL_RST;
            mask_q <= MDS_IRQ_MASK_RST;
            cfg_q <= MDS_CONFIG_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                MDS_SYNC_CONTROL_OFS: ctl_q <= reg_wdata;
                MDS_IRQ_MASK_OFS: mask_q <= reg_wdata;
                MDS_CONFIG_OFS: cfg_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Clock generation phase counter, free running
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + 1'b1;
        end
    end

    // FIFO-rate clock: one pulse every depth data clocks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fifo_div_q <= 3'h0;
        end else if (dclk_rise) begin
            fifo_div_q <= fifo_div_q + 3'h1;
        end
    end

    logic [PHASE_W-1:0] gap_q;
    logic [PHASE_W-1:0] gap;
    logic [2:0] fifo_ref_q;
    logic phase_ok;
    // Spacing of sync edges in phase counts; sync periods must stay below 2^PHASE_W
    assign gap = phase_q - ref_phase_q;
    assign phase_ok = (gap - gap_q <= PHASE_W'(MDS_PHASE_TOL)
        || gap_q - gap <= PHASE_W'(MDS_PHASE_TOL))
        && (!fifo_rate || fifo_div_q == fifo_ref_q);

    // Phase reference tracked in every state so a locked slip is seen
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_phase_q <= '0;
            gap_q <= '0;
            fifo_ref_q <= 3'h0;
        end else if (sync_ev) begin
            ref_phase_q <= phase_q;
            gap_q <= gap;
            fifo_ref_q <= fifo_div_q;
        end
    end

    // Lock acquisition: phase must stay constant for the averaged window
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= MDS_IDLE;
            lock_cnt_q <= 16'h0;
            avg_cnt_q <= 16'h0;
            locked_q <= 1'b0;
        end else if (!enable) begin
            state_q <= MDS_IDLE;
            locked_q <= 1'b0;
            lock_cnt_q <= 16'h0;
        end else begin
            if (lock_cnt_q != 16'hffff) begin
                lock_cnt_q <= lock_cnt_q + 16'h1;
            end
            unique case (state_q)
                MDS_IDLE: begin
                    state_q <= MDS_ACQUIRE;
                    lock_cnt_q <= 16'h0;
                    avg_cnt_q <= 16'h0;
                end
                MDS_ACQUIRE: begin
                    if (sync_ev) begin
                        if (!phase_ok) begin
                            avg_cnt_q <= 16'h0;
                        end else if (avg_cnt_q != 16'hffff) begin
                            avg_cnt_q <= avg_cnt_q + 16'h1;
                        end
                    end
                    if (lock_cnt_q >= lock_cycles(ctl_q[MDS_CTL_AVG_LSB +: MDS_CTL_AVG_W])
                            && avg_cnt_q >= avg_count(ctl_q[MDS_CTL_AVG_LSB +: MDS_CTL_AVG_W])) begin
                        state_q <= MDS_LOCKED;
                        locked_q <= 1'b1;
                    end
                end
                MDS_LOCKED: begin
                    if (sync_ev && !phase_ok) begin
                        state_q <= MDS_LOST;
                        locked_q <= 1'b0;
                    end
                end
                MDS_LOST: begin
                    state_q <= MDS_ACQUIRE;
                    lock_cnt_q <= 16'h0;
                    avg_cnt_q <= 16'h0;
                end
            endcase
        end
    end

    // Lost is sticky; a new loss wins over a same-cycle clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lost_q <= 1'b0;
        end else if (state_q == MDS_LOCKED && sync_ev && !phase_ok && enable) begin
            lost_q <= 1'b1;
        end else if (reg_wr && reg_addr == MDS_SYNC_STATUS_OFS && reg_wdata[MDS_STS_LOST_BIT]) begin
            lost_q <= 1'b0;
        end
    end

    // Frame must stay high one or two data clock periods before acting
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_cnt_q <= 2'h0;
            frame_done_q <= 1'b0;
        end else if (!frame_lvl) begin
            frame_cnt_q <= 2'h0;
            frame_done_q <= 1'b0;
        end else if (dclk_rise && frame_cnt_q != 2'h3) begin
            frame_cnt_q <= frame_cnt_q + 2'h1;
        end else if (frame_cnt_q >= (cfg_q[MDS_CFG_SINGLE_PORT_BIT]
                ? 2'(MDS_FRAME_SINGLE_PERIODS) : 2'(MDS_FRAME_DUAL_PERIODS))) begin
            frame_done_q <= 1'b1;
        end
    end

    logic realign_go;
    assign realign_go = frame_lvl && !frame_done_q && frame_cnt_q >= (cfg_q[MDS_CFG_SINGLE_PORT_BIT]
        ? 2'(MDS_FRAME_SINGLE_PERIODS) : 2'(MDS_FRAME_DUAL_PERIODS));

    // FIFO-rate mode resets to start level; data-rate mode to fixed offset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fifo_realign <= 1'b0;
            write_pointer <= 3'h0;
        end else begin
            fifo_realign <= realign_go;
            if (realign_go) begin
                write_pointer <= fifo_rate ? 3'h0 : 3'(MDS_FIFO_DEPTH / 2);
            end else if (dclk_rise) begin
                write_pointer <= write_pointer + 3'h1;
            end
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            MDS_SYNC_CONTROL_OFS: rdata_d = ctl_q;
            MDS_SYNC_STATUS_OFS: begin
                rdata_d[MDS_STS_LOST_BIT] = lost_q;
                rdata_d[MDS_STS_LOCKED_BIT] = locked_q;
            end
            MDS_IRQ_MASK_OFS: rdata_d = mask_q;
            MDS_CONFIG_OFS: rdata_d = cfg_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign irq = (lost_q & mask_q[MDS_STS_LOST_BIT]) | (locked_q & mask_q[MDS_STS_LOCKED_BIT]);

    sticky_lost_a: assert property (@(posedge ref_clk) disable iff (rst)
        lost_q && !(reg_wr && reg_addr == MDS_SYNC_STATUS_OFS) |=> lost_q)
        else $error("lost flag dropped without clear");
    lost_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        enable && state_q == MDS_LOCKED && sync_ev && !phase_ok |=> lost_q && !locked_q)
        else $error("loss not reported");
    locked_state_a: assert property (@(posedge ref_clk) disable iff (rst)
        locked_q == (state_q == MDS_LOCKED))
        else $error("locked flag disagrees with state");
    lock_time_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(locked_q) |-> $past(lock_cnt_q) >=
            lock_cycles(ctl_q[MDS_CTL_AVG_LSB +: MDS_CTL_AVG_W]))
        else $error("lock too early");
    mult_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
        use_mult |-> !fifo_rate)
        else $error("fifo rate with multiplier");
    realign_ptr_a: assert property (@(posedge ref_clk) disable iff (rst)
        realign_go && fifo_rate |=> fifo_realign && write_pointer == 3'h0)
        else $error("realign pointer wrong");
    realign_offset_a: assert property (@(posedge ref_clk) disable iff (rst)
        realign_go && !fifo_rate |=> fifo_realign && write_pointer == 3'(MDS_FIFO_DEPTH / 2))
        else $error("realign offset wrong");
    frame_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        fifo_realign |-> $past(frame_cnt_q) >= ($past(cfg_q[MDS_CFG_SINGLE_PORT_BIT])
            ? 2'(MDS_FRAME_SINGLE_PERIODS) : 2'(MDS_FRAME_DUAL_PERIODS)))
        else $error("realign before frame held");
    irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
        lost_q && mask_q[MDS_STS_LOST_BIT] |-> irq)
        else $error("irq missing");
endmodule // mds_sync_ctrl
`default_nettype wire

/* rtl/mds_pkg.sv */
package mds_pkg;
    // Register offsets
    localparam logic [7:0] MDS_SYNC_CONTROL_OFS = 8'h10;
    localparam logic [7:0] MDS_SYNC_STATUS_OFS = 8'h12;
    localparam logic [7:0] MDS_IRQ_MASK_OFS = 8'h13;
    localparam logic [7:0] MDS_CONFIG_OFS = 8'h14;
    // Sync control fields
    localparam int MDS_CTL_ENABLE_BIT = 7;
    localparam int MDS_CTL_DATA_RATE_BIT = 6;
    localparam int MDS_CTL_EDGE_BIT = 3;
    localparam int MDS_CTL_AVG_LSB = 0;
    localparam int MDS_CTL_AVG_W = 3;
    // Sync status fields
    localparam int MDS_STS_LOST_BIT = 7;
    localparam int MDS_STS_LOCKED_BIT = 6;
    // Config fields (clocking source, port mode)
    localparam int MDS_CFG_MULT_BIT = 0;
    localparam int MDS_CFG_SINGLE_PORT_BIT = 1;
    // Reset values
    localparam logic [7:0] MDS_SYNC_CONTROL_RST = 8'h00;
    localparam logic [7:0] MDS_IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] MDS_CONFIG_RST = 8'h00;
    // Timing counts
    localparam int MDS_LOCK_BASE = 11;
    localparam int MDS_LOCK_UNIT = 64;
    localparam int MDS_FIFO_DEPTH = 8;
    localparam int MDS_FRAME_DUAL_PERIODS = 1;
    localparam int MDS_FRAME_SINGLE_PERIODS = 2;
    localparam logic [2:0] MDS_PHASE_TOL = 3'h1;

    typedef enum logic [1:0] {
        MDS_IDLE = 2'b00,
        MDS_ACQUIRE = 2'b01,
        MDS_LOCKED = 2'b11,
        MDS_LOST = 2'b10
    } mds_state_type;
endpackage

/* rtl/mds_edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser with a rising-edge pulse taken after the second stage
module mds_edge_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
endmodule // mds_edge_sync
`default_nettype wire

/* testbench/mds_fpga_source.sv */
`timescale 1ns/10ps
`default_nettype none
// Behavioural data source: free-running data clock, periodic sync, frame strobe
module mds_fpga_source (
    input wire logic use_reference,
    input wire logic [4:0] sync_div,
    output logic reference_sync_input,
    output logic separate_sync_input,
    output logic source_data_clock,
    output logic frame_strobe
);
    logic sync_lvl;
    logic [7:0] noise_q;
    int rise_cnt;
    int slip_req;
    initial begin
        frame_strobe = 1'b0;
        noise_q = 8'ha5;
        rise_cnt = 0;
        slip_req = 0;
        source_data_clock = 1'b0;
        forever #200 source_data_clock = ~source_data_clock;
    end
    // Sync derived from the data clock so its phase stays fixed
    always @(posedge source_data_clock) begin
        noise_q <= {noise_q[6:0], noise_q[7] ^ noise_q[5] ^ noise_q[4] ^ noise_q[3]};
        if (slip_req != 0) begin
            slip_req <= 0;
        end else begin
            rise_cnt <= (rise_cnt + 1) % sync_div;
        end
    end
    assign sync_lvl = rise_cnt < sync_div / 2;
    // Unused pin carries noise so a wrong pin choice cannot lock
    assign reference_sync_input = use_reference ? sync_lvl : noise_q[0];
    assign separate_sync_input = use_reference ? noise_q[0] : sync_lvl;
    task automatic send_frame(input int rises);
        @(negedge source_data_clock);
        frame_strobe = 1'b1;
        repeat (rises) @(posedge source_data_clock);
        @(negedge source_data_clock);
        frame_strobe = 1'b0;
    endtask
    // One-off phase jump of one data period
    task automatic slip();
        slip_req = 1;
    endtask
endmodule // mds_fpga_source
`default_nettype wire

/* testbench/mds_sync_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module mds_sync_ctrl_tb
    import mds_pkg::*;
;
    logic ref_clk, rst, reg_wr, reg_rd, use_ref, rd_pend;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, last_rd;
    logic [4:0] sync_div;
    logic ref_sync, sep_sync, dclk, frame, fifo_realign, irq;
    logic [2:0] write_pointer;
    logic [15:0] note;
    logic [15:0] rd_notes[$];
    logic [2:0] wp_notes[$];
    logic [31:0] lfsr;
    int miscompares, samples_checked;
    mds_sync_ctrl i_mds_sync_ctrl (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reference_sync_input(ref_sync), .separate_sync_input(sep_sync),
        .source_data_clock(dclk), .frame_strobe(frame), .fifo_realign(fifo_realign),
        .write_pointer(write_pointer), .irq(irq));
    mds_fpga_source i_mds_fpga_source (.use_reference(use_ref), .sync_div(sync_div),
        .reference_sync_input(ref_sync), .separate_sync_input(sep_sync),
        .source_data_clock(dclk), .frame_strobe(frame));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd_notes.push_back({m, e});
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        last_rd = 8'h00;
        while (last_rd[b] !== 1'b1 && n < 400) begin
            rd(MDS_SYNC_STATUS_OFS, 8'h00, 8'h00);
            repeat (20) @(posedge ref_clk);
            n++;
        end
        chk("status poll", 8'h01, {7'h00, last_rd[b]});
    endtask
    task automatic frame_chk(input int rises, input int exp_wp);
        if (exp_wp >= 0) wp_notes.push_back(exp_wp[2:0]);
        i_mds_fpga_source.send_frame(rises);
        repeat (20) @(posedge ref_clk);
        chk("pending realign", 8'h00, 8'(wp_notes.size()));
    endtask
    // Read data stands one cycle only, so it is taken mid-cycle
    always @(negedge ref_clk) begin
        if (rd_pend) begin
            last_rd = reg_rdata;
            note = rd_notes.pop_front();
            chk("reg_rdata", note[7:0], reg_rdata & note[15:8]);
        end
        rd_pend = reg_rd;
        if (fifo_realign === 1'b1) begin
            if (wp_notes.size() == 0) chk("fifo_realign", 8'h00, 8'h01);
            else chk("write_pointer", {5'h0, wp_notes.pop_front()}, {5'h0, write_pointer});
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #3000000;
        miscompares++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        use_ref = 1'b0;
        sync_div = 5'd2;
        rd_pend = 1'b0;
        lfsr = 32'h3be0a0de;
        miscompares = 0;
        samples_checked = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(MDS_SYNC_CONTROL_OFS, 8'hff, MDS_SYNC_CONTROL_RST);
        rd(MDS_IRQ_MASK_OFS, 8'hff, MDS_IRQ_MASK_RST);
        rd(MDS_CONFIG_OFS, 8'hff, MDS_CONFIG_RST);
        rd(MDS_SYNC_STATUS_OFS, 8'hff, 8'h00);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wr({1'b1, lfsr[6:0]}, lfsr[15:8]);
            rd({1'b1, lfsr[6:0]}, 8'hff, 8'h00);
        end
        wr(MDS_SYNC_CONTROL_OFS, 8'hc0);
        rd(MDS_SYNC_CONTROL_OFS, 8'hff, 8'hc0);
        repeat (700) @(posedge ref_clk);
        rd(MDS_SYNC_STATUS_OFS, 8'h40, 8'h00);
        poll(MDS_STS_LOCKED_BIT);
        rd(MDS_SYNC_STATUS_OFS, 8'hff, 8'h40);
        chk("irq", 8'h00, {7'h00, irq});
        frame_chk(1, 4);
        wr(MDS_IRQ_MASK_OFS, 8'h40);
        @(negedge ref_clk);
        chk("irq", 8'h01, {7'h00, irq});
        wr(MDS_IRQ_MASK_OFS, 8'h80);
        i_mds_fpga_source.slip();
        poll(MDS_STS_LOST_BIT);
        chk("irq", 8'h01, {7'h00, irq});
        poll(MDS_STS_LOCKED_BIT);
        rd(MDS_SYNC_STATUS_OFS, 8'hc0, 8'hc0);
        wr(MDS_SYNC_STATUS_OFS, 8'hc0);
        rd(MDS_SYNC_STATUS_OFS, 8'hff, 8'h40);
        chk("irq", 8'h00, {7'h00, irq});
        wr(MDS_SYNC_CONTROL_OFS, 8'h80);
        sync_div <= 5'd16;
        repeat (1500) @(posedge ref_clk);
        wr(MDS_SYNC_STATUS_OFS, 8'h80);
        poll(MDS_STS_LOCKED_BIT);
        frame_chk(1, 0);
        wr(MDS_CONFIG_OFS, 8'h02);
        frame_chk(1, -1);
        frame_chk(2, 0);
        wr(MDS_SYNC_CONTROL_OFS, 8'hc9);
        wr(MDS_CONFIG_OFS, 8'h03);
        use_ref <= 1'b1;
        sync_div <= 5'd2;
        repeat (1500) @(posedge ref_clk);
        wr(MDS_SYNC_STATUS_OFS, 8'h80);
        poll(MDS_STS_LOCKED_BIT);
        rd(MDS_CONFIG_OFS, 8'hff, 8'h03);
        rd(MDS_SYNC_CONTROL_OFS, 8'hff, 8'hc9);
        frame_chk(2, 4);
        conclude();
    end
endmodule // mds_sync_ctrl_tb
`default_nettype wire
